// *** core/tcc_pkg.sv ***
// tcc_pkg: register map, field positions and reset values of the timer core.
// assumes a 32-bit AHB-Lite slave with one register per aligned word.
package tcc_pkg;

    // register indices as printed; byte address = index * 4
    localparam logic [7:0] TCC_IDX_STATUS    = 8'h40;
    localparam logic [7:0] TCC_IDX_CNT_HI    = 8'h41;
    localparam logic [7:0] TCC_IDX_CNT_LO    = 8'h42;
    localparam logic [7:0] TCC_IDX_LIM_HI    = 8'h43;
    localparam logic [7:0] TCC_IDX_LIM_LO    = 8'h44;
    localparam logic [7:0] TCC_IDX_CH0_CTRL  = 8'h45;
    localparam logic [7:0] TCC_IDX_CH0_VALHI = 8'h46;
    localparam logic [7:0] TCC_IDX_CH0_VALLO = 8'h47;
    localparam logic [7:0] TCC_IDX_CH1_CTRL  = 8'h48;
    localparam logic [7:0] TCC_IDX_CH1_VALHI = 8'h49;
    localparam logic [7:0] TCC_IDX_CH1_VALLO = 8'h4a;

    // timer_status_control fields
    localparam int TCC_ST_FLAG = 7;
    localparam int TCC_ST_IE   = 6;
    localparam int TCC_ST_HALT = 5;
    localparam int TCC_ST_RST  = 4;

    // channel status/control fields
    localparam int TCC_CH_FLAG = 7;
    localparam int TCC_CH_IE   = 6;
    localparam int TCC_CH_BUF  = 5;
    localparam int TCC_CH_MSA  = 4;
    localparam int TCC_CH_ELSB = 3;
    localparam int TCC_CH_ELSA = 2;
    localparam int TCC_CH_TOV  = 1;
    localparam int TCC_CH_MAX  = 0;

    // prescale codes and reset values
    localparam logic [2:0]  TCC_PS_DIV1   = 3'h0;
    localparam logic [2:0]  TCC_PS_EXT    = 3'h7;
    localparam logic [15:0] TCC_LIM_RESET = 16'hffff;
    localparam logic [7:0]  TCC_CTL_RESET = 8'h00;
    localparam int          TCC_PRESC_W   = 6;

    // edge/level select encodings
    localparam logic [1:0] TCC_ELS_OFF    = 2'h0;
    localparam logic [1:0] TCC_ELS_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ELS_CLEAR  = 2'h2;
    localparam logic [1:0] TCC_ELS_SET    = 2'h3;

endpackage : tcc_pkg

// *** core/tcc_timer_core.sv ***
// tcc_timer_core: 16-bit modulo timer with prescaler and two capture/compare channels.
// assumes one 25 MHz clock, pins synchronous to it, zero-wait AHB-Lite word access.
`timescale 1ns/10ps
module tcc_timer_core (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        external_count_clock_in,
    input  wire logic        port_d_direction_bit6_in,
    output logic             external_count_clock_oe_out,
    input  wire logic [1:0]  channel_pin_in,
    output logic      [1:0]  channel_pin_out,
    output logic      [1:0]  channel_pin_oe_out,
    output logic             overflow_irq_out,
    output logic      [1:0]  channel_irq_out
);
    import tcc_pkg::*;

    // bus state
    logic        dp_wr_q;
    logic [7:0]  dp_idx_q;
    // counter state
    logic        ovf_flag_q;
    logic        ovf_ie_q;
    logic        halt_q;
    logic [2:0]  ps_q;
    logic        ovf_armed_q;
    logic [15:0] cnt_q;
    logic [15:0] lim_q;
    logic        lim_inh_q;
    logic [TCC_PRESC_W-1:0] presc_q;
    logic [7:0]  lat_lo_q;
    logic        lat_valid_q;
    logic        ext_prev_q;
    logic        buf_last_q;
    logic        buf_sel_q;
    // per-channel state
    logic [7:0]  ctl_q      [2];
    logic [15:0] val_q      [2];
    logic        val_inh_q  [2];
    logic        ch_armed_q [2];
    logic        pin_prev_q [2];

    // address phase decode; accesses above the 1 KiB window read zero
    wire        addr_ok  = hsel_in & htrans_in[1] & hready_in;
    wire [7:0]  a_idx    = haddr_in[9:2];
    wire        a_map    = (haddr_in[31:10] == 22'h0);
    wire        rd_ev    = addr_ok & ~hwrite_in & a_map;
    wire [7:0]  w        = hwdata_in[7:0];
    wire        rd_st    = rd_ev & (a_idx == TCC_IDX_STATUS);
    wire        rd_cnthi = rd_ev & (a_idx == TCC_IDX_CNT_HI);
    wire        rd_cntlo = rd_ev & (a_idx == TCC_IDX_CNT_LO);
    wire        wr_st    = dp_wr_q & (dp_idx_q == TCC_IDX_STATUS);
    wire        wr_limhi = dp_wr_q & (dp_idx_q == TCC_IDX_LIM_HI);
    wire        wr_limlo = dp_wr_q & (dp_idx_q == TCC_IDX_LIM_LO);

    // tick generation: prescaler taps or rising edge of the external tick
    wire [TCC_PRESC_W-1:0] presc_mask =
        TCC_PRESC_W'((7'h01 << ps_q) - 7'h01);
    wire presc_tick = ((presc_q & presc_mask) == presc_mask);
    wire ext_edge   = external_count_clock_in & ~ext_prev_q;
    wire tick       = ~halt_q & ((ps_q == TCC_PS_EXT) ? ext_edge : presc_tick);
    wire wrap       = tick & (cnt_q == lim_q);
    wire [15:0] cnt_next = wrap ? 16'h0000 : cnt_q + 16'h0001;
    wire trst       = wr_st & w[TCC_ST_RST];
    wire ovf_set    = wrap & ~lim_inh_q;
    // only a zero written after an armed read clears; a one is ignored
    wire ovf_clr    = wr_st & ~w[TCC_ST_FLAG] & ovf_armed_q;

    // register read mux
    wire [7:0] rd_st_b  = {ovf_flag_q, ovf_ie_q, halt_q, 2'h0, ps_q};
    wire [7:0] rd_lo_b  = lat_valid_q ? lat_lo_q : cnt_q[7:0];
    wire [7:0] ctl1_rd  = {ctl_q[1][7:6], 1'b0, ctl_q[1][4:0]};
    wire [7:0] rd_byte  =
        (a_idx == TCC_IDX_STATUS)    ? rd_st_b     :
        (a_idx == TCC_IDX_CNT_HI)    ? cnt_q[15:8] :
        (a_idx == TCC_IDX_CNT_LO)    ? rd_lo_b     :
        (a_idx == TCC_IDX_LIM_HI)    ? lim_q[15:8] :
        (a_idx == TCC_IDX_LIM_LO)    ? lim_q[7:0]  :
        (a_idx == TCC_IDX_CH0_CTRL)  ? ctl_q[0]    :
        (a_idx == TCC_IDX_CH0_VALHI) ? val_q[0][15:8] :
        (a_idx == TCC_IDX_CH0_VALLO) ? val_q[0][7:0]  :
        (a_idx == TCC_IDX_CH1_CTRL)  ? ctl1_rd     :
        (a_idx == TCC_IDX_CH1_VALHI) ? val_q[1][15:8] :
        (a_idx == TCC_IDX_CH1_VALLO) ? val_q[1][7:0]  : 8'h00;

    // bus slave: zero wait states, read data registered for the data phase
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dp_wr_q       <= 1'b0;
            dp_idx_q      <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            dp_wr_q       <= addr_ok & hwrite_in & a_map;
            dp_idx_q      <= a_idx;
            hrdata_out    <= rd_ev ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // status/control; set beats clear and a set after the read disarms
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovf_flag_q  <= 1'b0;
            ovf_ie_q    <= 1'b0;
            halt_q      <= 1'b1;
            ps_q        <= TCC_PS_DIV1;
            ovf_armed_q <= 1'b0;
        end else begin
            ovf_flag_q <= ovf_set | (ovf_flag_q & ~ovf_clr);
            if (wr_st) begin
                ovf_ie_q <= w[TCC_ST_IE];
                halt_q   <= w[TCC_ST_HALT];
                ps_q     <= w[2:0];
            end
            if (ovf_set)
                ovf_armed_q <= 1'b0;
            else if (rd_st & ovf_flag_q)
                ovf_armed_q <= 1'b1;
            else if (wr_st)
                ovf_armed_q <= 1'b0;
        end
    end

    // counter, prescaler and low-byte latch
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_q       <= 16'h0000;
            presc_q     <= '0;
            lat_lo_q    <= 8'h00;
            lat_valid_q <= 1'b0;
            ext_prev_q  <= 1'b0;
        end else begin
            ext_prev_q <= external_count_clock_in;
            if (trst) begin
                cnt_q       <= 16'h0000;
                presc_q     <= '0;
                lat_valid_q <= 1'b0;
            end else begin
                if (tick)
                    cnt_q <= cnt_next;
                if (!halt_q)
                    presc_q <= presc_q + 1'b1;
                if (rd_cnthi && !lat_valid_q) begin
                    lat_lo_q    <= cnt_q[7:0];
                    lat_valid_q <= 1'b1;
                end else if (rd_cntlo) begin
                    lat_valid_q <= 1'b0;
                end
            end
        end
    end

    // limit registers; the high byte holds off the flag until the low byte lands
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lim_q     <= TCC_LIM_RESET;
            lim_inh_q <= 1'b0;
        end else if (wr_limhi) begin
            lim_q[15:8] <= w;
            lim_inh_q   <= 1'b1;
        end else if (wr_limlo) begin
            lim_q[7:0]  <= w;
            lim_inh_q   <= 1'b0;
        end
    end

    // interrupt requests and external clock pin direction
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            overflow_irq_out            <= 1'b0;
            external_count_clock_oe_out <= 1'b0;
        end else begin
            overflow_irq_out            <= ovf_flag_q & ovf_ie_q;
            external_count_clock_oe_out <=
                port_d_direction_bit6_in & (ps_q != TCC_PS_EXT);
        end
    end

    // buffered pair: the last-written value set takes over at each wrap
    wire wr_v0lo = dp_wr_q & (dp_idx_q == TCC_IDX_CH0_VALLO);
    wire wr_v1lo = dp_wr_q & (dp_idx_q == TCC_IDX_CH1_VALLO);
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            buf_last_q <= 1'b0;
            buf_sel_q  <= 1'b0;
        end else begin
            if (wr_v1lo)
                buf_last_q <= 1'b1;
            else if (wr_v0lo)
                buf_last_q <= 1'b0;
            if (!ctl_q[0][TCC_CH_BUF])
                buf_sel_q <= 1'b0;
            else if (wrap)
                buf_sel_q <= buf_last_q;
        end
    end

    // capture/compare channels
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            localparam logic [7:0] IDX_CTL = (gi == 0) ? TCC_IDX_CH0_CTRL  : TCC_IDX_CH1_CTRL;
            localparam logic [7:0] IDX_VH  = (gi == 0) ? TCC_IDX_CH0_VALHI : TCC_IDX_CH1_VALHI;
            localparam logic [7:0] IDX_VL  = (gi == 0) ? TCC_IDX_CH0_VALLO : TCC_IDX_CH1_VALLO;
            wire [7:0] c      = ctl_q[gi];
            wire [1:0] els    = c[TCC_CH_ELSB:TCC_CH_ELSA];
            // channel 1 loses capture, compare and control bits 6:0 while channel 0 runs buffered
            wire       en     = (gi == 0) ? 1'b1 : ~ctl_q[0][TCC_CH_BUF];
            wire       buf_m  = (gi == 0) ? c[TCC_CH_BUF] : 1'b0;
            wire       cap_m  = en & ~buf_m & ~c[TCC_CH_MSA] & (els != TCC_ELS_OFF);
            wire       cmp_m  = en & (buf_m | c[TCC_CH_MSA]);
            wire       rise   = channel_pin_in[gi] & ~pin_prev_q[gi];
            wire       fall   = ~channel_pin_in[gi] & pin_prev_q[gi];
            wire       cap_ev = cap_m & ~halt_q &
                                ((rise & els[0]) | (fall & els[1]));
            wire       use1   = buf_m & buf_sel_q;
            wire [15:0] cval  = use1 ? val_q[1] : val_q[gi];
            wire       inh    = use1 ? val_inh_q[1] : val_inh_q[gi];
            wire       cmp_ev = cmp_m & tick & (cnt_next == cval) & ~inh;
            wire       ev     = cap_ev | cmp_ev;
            wire       rd_c   = rd_ev & (a_idx == IDX_CTL);
            wire       wr_c   = dp_wr_q & (dp_idx_q == IDX_CTL) & en;
            wire       wr_vh  = dp_wr_q & (dp_idx_q == IDX_VH);
            wire       wr_vl  = dp_wr_q & (dp_idx_q == IDX_VL);
            wire       clr    = wr_c & ~w[TCC_CH_FLAG] & ch_armed_q[gi];
            wire [6:0] wmask  = (gi == 0) ? 7'h7f : 7'h5f;   // bit 5 reserved on channel 1
            // output level: preset, forced full duty, wrap toggle, compare action
            wire       cur    = channel_pin_out[gi];
            wire       act    = (els == TCC_ELS_TOGGLE) ? ~cur :
                                (els == TCC_ELS_SET);
            wire       out_d  = (els == TCC_ELS_OFF) ? ~c[TCC_CH_MSA] :
                                (c[TCC_CH_MAX] & ~c[TCC_CH_TOV]) ? 1'b1 :
                                (wrap & c[TCC_CH_TOV]) ? ~cur :      // wrap beats compare
                                cmp_ev ? act : cur;

            // control register with sticky event flag
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    ctl_q[gi]      <= TCC_CTL_RESET;
                    ch_armed_q[gi] <= 1'b0;
                end else begin
                    ctl_q[gi][TCC_CH_FLAG] <= ev | (c[TCC_CH_FLAG] & ~clr);
                    if (wr_c)
                        ctl_q[gi][6:0] <= w[6:0] & wmask;
                    else if (!en)
                        ctl_q[gi][6:0] <= 7'h00;
                    if (ev)
                        ch_armed_q[gi] <= 1'b0;
                    else if (rd_c & c[TCC_CH_FLAG])
                        ch_armed_q[gi] <= 1'b1;
                    else if (wr_c)
                        ch_armed_q[gi] <= 1'b0;
                end
            end

            // value register: capture target or compare value
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    val_q[gi]     <= 16'h0000;
                    val_inh_q[gi] <= 1'b0;
                end else if (wr_vh) begin
                    val_q[gi][15:8] <= w;
                    val_inh_q[gi]   <= 1'b1;
                end else if (wr_vl) begin
                    val_q[gi][7:0]  <= w;
                    val_inh_q[gi]   <= 1'b0;
                end else if (cap_ev) begin
                    val_q[gi] <= cnt_q;
                end
            end

            // pin driver; the pin is released when edge/level select is off
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    pin_prev_q[gi]         <= 1'b0;
                    channel_pin_out[gi]    <= 1'b0;
                    channel_pin_oe_out[gi] <= 1'b0;
                    channel_irq_out[gi]    <= 1'b0;
                end else begin
                    pin_prev_q[gi]         <= channel_pin_in[gi];
                    channel_pin_out[gi]    <= out_d;
                    channel_pin_oe_out[gi] <= cmp_m & (els != TCC_ELS_OFF);
                    channel_irq_out[gi]    <= c[TCC_CH_FLAG] & c[TCC_CH_IE];
                end
            end
        end
    endgenerate

endmodule : tcc_timer_core

// *** verif/tcc_timer_core_sva.sv ***
// tcc_timer_core_sva: port-level checks of the timer core.
// assumes zero-wait AHB-Lite word access; shadows status and ch0 control from bus writes.
`timescale 1ns/10ps
module tcc_timer_core_sva
    import tcc_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        port_d_direction_bit6_in,
    input wire logic        external_count_clock_oe_out,
    input wire logic [1:0]  channel_pin_oe_out,
    input wire logic        overflow_irq_out,
    input wire logic [1:0]  channel_irq_out
);
    logic       ap_q;
    logic       wr_q;
    logic [7:0] idx_q;
    logic [7:0] st_q;
    logic [7:0] c0_q;
    // decode of the address phase and of the data phase that follows it
    wire take_w = hsel_in && htrans_in[1] && hready_in && haddr_in[31:10] == 22'h0;
    wire wst_w  = ap_q && wr_q && hready_in && idx_q == TCC_IDX_STATUS;
    wire wc0_w  = ap_q && wr_q && hready_in && idx_q == TCC_IDX_CH0_CTRL;
    wire rst_w  = ap_q && !wr_q && idx_q == TCC_IDX_STATUS;
    wire rc0_w  = ap_q && !wr_q && idx_q == TCC_IDX_CH0_CTRL;
    // shadow keeps only software-owned bits; flags are left to the bench
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ap_q  <= 1'b0;
            wr_q  <= 1'b0;
            idx_q <= 8'h00;
            st_q  <= 8'h20;
            c0_q  <= 8'h00;
        end else begin
            ap_q  <= take_w;
            wr_q  <= hwrite_in;
            idx_q <= haddr_in[9:2];
            st_q  <= wst_w ? (hwdata_in[7:0] & 8'h67) : st_q;
            c0_q  <= wc0_w ? (hwdata_in[7:0] & 8'h7f) : c0_q;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_st_read; rst_w |-> hrdata_out[6:0] == st_q[6:0]; endproperty
    a_st_read: assert property (p_st_read) else $error("status readback wrong");
    property p_ch_read; rc0_w |-> hrdata_out[6:0] == c0_q[6:0]; endproperty
    a_ch_read: assert property (p_ch_read) else $error("ch0 control readback wrong");
    property p_ext_off; st_q[2:0] == 3'h7 |=> !external_count_clock_oe_out; endproperty
    a_ext_off: assert property (p_ext_off) else $error("ext clock pin driven");
    property p_ext_on;
        st_q[2:0] != 3'h7 && port_d_direction_bit6_in |=> external_count_clock_oe_out;
    endproperty
    a_ext_on: assert property (p_ext_on) else $error("ext pin direction lost");
    property p_ovf_irq; overflow_irq_out |-> $past(st_q[6]); endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq while disabled");
    property p_ch_irq; channel_irq_out[0] |-> $past(c0_q[6]); endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("ch0 irq while disabled");
    property p_cap_in; !c0_q[5] && !c0_q[4] |=> !channel_pin_oe_out[0]; endproperty
    a_cap_in: assert property (p_cap_in) else $error("capture pin driven");
    property p_cmp_out; c0_q[4] && c0_q[3:2] != 2'h0 |=> channel_pin_oe_out[0]; endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("compare pin not driven");
    property p_buf_ch1; c0_q[5] |=> !channel_pin_oe_out[1]; endproperty
    a_buf_ch1: assert property (p_buf_ch1) else $error("ch1 pin kept in buffered mode");
endmodule : tcc_timer_core_sva

bind tcc_timer_core tcc_timer_core_sva u_sva (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out),
    .port_d_direction_bit6_in(port_d_direction_bit6_in),
    .external_count_clock_oe_out(external_count_clock_oe_out),
    .channel_pin_oe_out(channel_pin_oe_out), .overflow_irq_out(overflow_irq_out),
    .channel_irq_out(channel_irq_out)
);

// *** verif/testbench.sv ***
// testbench: drives the timer core over AHB-Lite and its pins, checks registers and irqs.
// assumes a zero-wait slave; hready is looped back from hreadyout.
`timescale 1ns/10ps
module testbench;
    import tcc_pkg::*;
    logic        clk = 0, rst_n = 0, hsel = 0, hwr = 0, ext = 0, dir = 1;
    logic [31:0] ha = 0, hwd = 0, hrd;
    logic [1:0]  htr = 0, pin = 0, cp_out, cp_oe, cirq;
    logic        hrdy, hresp, ext_oe, oirq, rdph = 0;
    logic [7:0]  rdv, v;
    logic [15:0] nt;
    logic [15:0] exq[$];
    int          n_fail = 0, check_count = 0, cyc = 0, t0 = 0;

    tcc_timer_core dut (.clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(ha),
        .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(hrdy),
        .hrdata_out(hrd), .hreadyout_out(hrdy), .hresp_out(hresp),
        .external_count_clock_in(ext), .port_d_direction_bit6_in(dir),
        .external_count_clock_oe_out(ext_oe), .channel_pin_in(pin), .channel_pin_out(cp_out),
        .channel_pin_oe_out(cp_oe), .overflow_irq_out(oirq), .channel_irq_out(cirq));

    always #20 clk = ~clk;

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // cycle count; a hang ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    // each read data phase takes the oldest note; zero mask means judged by the driver
    always @(posedge clk) begin
        if (rdph && exq.size() > 0) begin
            nt = exq.pop_front();
            if (nt[15:8] != 8'h00) check(hrd[7:0] & nt[15:8], nt[7:0]);
        end
        rdph <= hsel && htr[1] && !hwr;
    end

    task automatic ap(input logic [7:0] idx, input logic w);
        ha   <= {22'h0, idx, 2'h0};
        htr  <= 2'h2;
        hwr  <= w;
        hsel <= 1'b1;
        do @(posedge clk); while (!hrdy);
        htr  <= 2'h0;
        hsel <= 1'b0;
    endtask : ap

    // note = {mask, expected byte}
    task automatic rd(input logic [7:0] idx, input logic [15:0] note);
        exq.push_back(note);
        ap(idx, 1'b0);
        do @(posedge clk); while (!hrdy);
        rdv = hrd[7:0];
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        ap(idx, 1'b1);
        hwd <= {24'h0, d};
        do @(posedge clk); while (!hrdy);
    endtask : wr

    task automatic stat(input logic [7:0] d);
        wr(TCC_IDX_STATUS, d);
        t0 = cyc;
    endtask : stat

    // divide-by-64 waits are taken mid-tick so a cycle of latency never moves the count
    task automatic wt(input int n);
        while (cyc - t0 < n) @(posedge clk);
    endtask : wt

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    initial begin
        void'($urandom(32'h9056));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(TCC_IDX_STATUS, 16'hff20);
        rd(TCC_IDX_LIM_HI, 16'hffff);
        rd(TCC_IDX_LIM_LO, 16'hffff);
        rd(TCC_IDX_CH0_CTRL, 16'hff00);
        rd(TCC_IDX_CH1_CTRL, 16'hff00);
        rd(TCC_IDX_CNT_LO, 16'hff00);
        wr(8'h00, 8'h5a);
        rd(8'h00, 16'hff00);
        // every internal divider: about 40 ticks in 40 periods
        for (int p = 0; p < 7; p++) begin
            stat(8'h30 | 8'(p));
            rd(TCC_IDX_CNT_LO, 16'hff00);
            stat(8'h10 | 8'(p));
            wt(40 << p);
            wr(TCC_IDX_STATUS, 8'h20 | 8'(p));
            rd(TCC_IDX_STATUS, {8'hff, 8'h20 | 8'(p)});
            rd(TCC_IDX_CNT_LO, 16'h0000);
            check(8'((rdv - 8'd39) <= 8'd4), 8'h01);
        end
        // external tick with random widths above the minimum pulse
        stat(8'h37);
        stat(8'h17);
        repeat (10) begin
            repeat ($urandom_range(2, 5)) @(posedge clk);
            ext <= 1'b1;
            repeat ($urandom_range(2, 5)) @(posedge clk);
            ext <= 1'b0;
        end
        check(8'(ext_oe), 8'h00);
        wr(TCC_IDX_STATUS, 8'h27);
        rd(TCC_IDX_CNT_LO, 16'hff0a);
        // limit 3 at divide-by-64: one wrap every 256 cycles
        stat(8'h36);
        wr(TCC_IDX_LIM_HI, 8'h00);
        wr(TCC_IDX_LIM_LO, 8'h03);
        stat(8'h16);
        wt(64 * 5 + 32);
        rd(TCC_IDX_STATUS, 16'hff86);
        rd(TCC_IDX_CNT_LO, 16'hff01);
        wr(TCC_IDX_STATUS, 8'h86);
        rd(TCC_IDX_STATUS, 16'hff86);
        wr(TCC_IDX_STATUS, 8'h06);
        rd(TCC_IDX_STATUS, 16'hff06);
        wt(64 * 9 + 32);
        rd(TCC_IDX_STATUS, 16'hff86);
        wt(64 * 13 + 32);
        wr(TCC_IDX_STATUS, 8'h46);      // a wrap came between read and write
        rd(TCC_IDX_STATUS, 16'hffc6);
        check(8'(oirq), 8'h01);
        wr(TCC_IDX_STATUS, 8'h06);
        wt(64 * 17 + 32);
        check(8'(oirq), 8'h00);
        rd(TCC_IDX_STATUS, 16'hff86);
        wr(TCC_IDX_STATUS, 8'hc6);
        rd(TCC_IDX_STATUS, 16'hffc6);
        check(8'(oirq), 8'h01);
        wr(TCC_IDX_STATUS, 8'h46);
        settle();
        check(8'(oirq), 8'h00);
        wr(TCC_IDX_LIM_HI, 8'h00);      // low byte still pending
        wt(64 * 21 + 32);
        rd(TCC_IDX_STATUS, 16'hff46);
        wr(TCC_IDX_LIM_LO, 8'h03);
        wt(64 * 25 + 32);
        rd(TCC_IDX_STATUS, 16'hffc6);
        stat(8'hd6);                    // counter reset, flag must survive
        wt(64 + 32);
        rd(TCC_IDX_STATUS, 16'hffc6);
        rd(TCC_IDX_CNT_HI, 16'hff00);
        wt(64 * 3 + 32);
        rd(TCC_IDX_CNT_HI, 16'hff00);
        rd(TCC_IDX_CNT_LO, 16'hff01);
        rd(TCC_IDX_CNT_LO, 16'hff03);
        wr(TCC_IDX_STATUS, 8'he6);
        wt(64 * 9);
        rd(TCC_IDX_CNT_LO, 16'hff03);
        // capture on both edges while halted: no flag
        wr(TCC_IDX_CH0_CTRL, 8'h0c);
        pin[0] <= 1'b1;
        settle();
        pin[0] <= 1'b0;
        settle();
        rd(TCC_IDX_CH0_CTRL, 16'hff0c);
        wr(TCC_IDX_STATUS, 8'h86);
        for (int e = 1; e < 4; e++) begin
            for (int l = 1; l >= 0; l--) begin
                v = 8'h40 | 8'(e << 2);
                v[7] = l[0] ? v[2] : v[3];
                // select the edge under test before the pin moves
                wr(TCC_IDX_CH0_CTRL, v & 8'h7f);
                pin[0] <= l[0];
                settle();
                rd(TCC_IDX_CH0_CTRL, {8'hff, v});
                check(8'(cirq[0]), 8'(v[7]));
                wr(TCC_IDX_CH0_CTRL, v & 8'h7f);
            end
        end
        pin[0] <= 1'b1;
        settle();
        rd(TCC_IDX_CH0_CTRL, 16'hffcc);
        pin[0] <= 1'b0;
        settle();
        wr(TCC_IDX_CH0_CTRL, 8'h4c);
        rd(TCC_IDX_CH0_CTRL, 16'hffcc);
        // halt first: a stale captured value could match while buffered with no action
        wr(TCC_IDX_STATUS, 8'ha6);
        wr(TCC_IDX_CH0_CTRL, 8'h20);
        wr(TCC_IDX_CH1_CTRL, 8'h44);
        rd(TCC_IDX_CH1_CTRL, 16'hff00);
        rd(TCC_IDX_CH0_CTRL, 16'hff20);
        wr(TCC_IDX_CH0_VALHI, 8'h00);
        wr(TCC_IDX_CH0_VALLO, 8'h02);
        wr(TCC_IDX_CH0_CTRL, 8'h18);
        wr(TCC_IDX_STATUS, 8'h86);
        repeat (300) @(posedge clk);
        rd(TCC_IDX_CH0_CTRL, 16'hff98);
        check(8'(cp_oe[0]), 8'h01);
        check(8'(cp_out[0]), 8'h00);
        check(8'(cirq[1]), 8'h00);
        results();
    end
endmodule : testbench
